// File: verilog/asac_sequencer.sv
// Purpose: Conversion sequencing and sticky alert status behind the serial register port.
// Assumes: A bus engine on clock_i decodes start, stop, address and acknowledge.
// Notes:   Analog conversion and limit compare live outside; they return one result.
`timescale 1ns/1ps
`include "asac_defines.svh"
module asac_sequencer #(
    parameter int TMO_CYC  = `ASAC_TMO_CYC,
    parameter int AUTO_CYC = `ASAC_AUTO_CYC
) (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    // Byte events from the bus engine
    input  wire logic        bus_start_i,
    input  wire logic        bus_stop_i,
    input  wire logic        wr_valid_i,
    input  wire logic [7:0]  wr_byte_i,
    input  wire logic        rd_begin_i,
    input  wire logic        rd_byte_req_i,
    input  wire logic        rd_nack_i,
    output logic      [7:0]  rd_byte_o,
    // Converter
    output logic             conv_start_o,
    output logic      [2:0]  conv_chan_o,
    input  wire logic        conv_done_i,
    input  wire logic [11:0] conv_data_i,
    input  wire logic        conv_hi_i,
    input  wire logic        conv_lo_i,
    input  wire logic        int_temp_hi_i,
    input  wire logic        int_temp_lo_i,
    // Fault pins
    input  wire logic [1:0]  ovr_pin_i,
    input  wire logic        overtemp_pin_i,
    input  wire logic [1:0]  diode_open_pin_i,
    // Status outputs
    output logic             cmd_mode_o,
    output logic             dac_hiz_o,
    output logic             alert_pin_o
);
    asac_pkg::asac_state_t st_reg;
    asac_pkg::asac_state_t st_next;
    logic [4:0]  pins_s;
    logic        req_v;
    logic [2:0]  req_ch;
    logic        cmd_wr_ev;
    logic        any_st;
    logic        wide;
    logic [15:0] word;
    logic [2:0]  pos;

    asac_pin_sync #(
        .W (5)
    ) u_pins (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .pin_i   ({diode_open_pin_i, overtemp_pin_i, ovr_pin_i}),
        .level_o (pins_s)
    );

    // Next selected channel after cur, wrapping past the last one.
    function automatic logic [2:0] next_ch(input logic [7:0] mask, input logic [2:0] cur);
        logic [2:0] c;
        logic [2:0] r;
        logic       hit;
        r   = cur;
        hit = 1'b0;
        for (int i = 1; i <= 8; i++) begin
            c = cur + i[2:0];
            if (!hit && mask[c]) begin
                r   = c;
                hit = 1'b1;
            end
        end
        return r;
    endfunction

    // ********************
    // Next state
    // ********************
    always_comb begin
        st_next            = st_reg;
        st_next.conv_start = 1'b0;
        req_v              = 1'b0;
        req_ch             = st_reg.cur_ch;
        cmd_wr_ev          = 1'b0;
        wide               = 1'b0;
        word               = `ASAC_RST16;
        pos                = st_reg.cur_ch[2] ? {1'b0, st_reg.cur_ch[0], 1'b0}
                                              : {st_reg.cur_ch[1:0], 1'b0};
        any_st             = |{st_reg.vst, st_reg.ist, st_reg.tst};

        // Background pacing only while on-demand mode is idle.
        if (st_reg.cfg[`ASAC_CFG_AUTO] && st_reg.seq != `ASAC_RST8 && !st_reg.cmd_on) begin
            if (st_reg.aut == 20'(AUTO_CYC - 1)) begin
                st_next.aut = '0;
                req_v       = 1'b1;
                req_ch      = next_ch(st_reg.seq, st_reg.cur_ch);
            end else begin
                st_next.aut = st_reg.aut + 20'h00001;
            end
        end else begin
            st_next.aut = '0;
        end

        if (st_reg.cmd_on) begin
            if (st_reg.tmo == 20'(TMO_CYC - 1)) begin
                st_next.cmd_on = 1'b0;
            end else begin
                st_next.tmo = st_reg.tmo + 20'h00001;
            end
        end

        // Register writes.
        if (bus_start_i) begin
            st_next.wph = asac_pkg::ASAC_W_PTR;
        end else if (wr_valid_i) begin
            unique case (st_reg.wph)
                asac_pkg::ASAC_W_PTR: begin
                    st_next.wtgt = wr_byte_i;
                    if (wr_byte_i != `ASAC_PTR_CMD) begin
                        st_next.ptr = wr_byte_i;
                    end
                    st_next.wph = (wr_byte_i == `ASAC_PTR_RESULT || wr_byte_i == `ASAC_PTR_CFG)
                                ? asac_pkg::ASAC_W_HI : asac_pkg::ASAC_W_B8;
                end
                asac_pkg::ASAC_W_HI: begin
                    st_next.whi = wr_byte_i;
                    st_next.wph = asac_pkg::ASAC_W_LO;
                end
                asac_pkg::ASAC_W_LO: begin
                    if (st_reg.wtgt == `ASAC_PTR_CFG) begin
                        st_next.cfg = {st_reg.whi, wr_byte_i};
                        if (wr_byte_i[`ASAC_CFG_CLR_A] && wr_byte_i[`ASAC_CFG_CLR_B]) begin
                            st_next.vst = `ASAC_RST8;
                            st_next.ist = `ASAC_RST8;
                            st_next.tst = `ASAC_RST8;
                        end
                    end
                    st_next.wph = asac_pkg::ASAC_W_PTR;
                end
                asac_pkg::ASAC_W_B8: begin
                    case (st_reg.wtgt)
                        `ASAC_PTR_CMD: begin
                            st_next.cmd_mask = wr_byte_i;
                            st_next.cmd_on   = wr_byte_i != `ASAC_RST8;
                            st_next.cmd_read = 1'b0;
                            st_next.cmd_one  = 1'b0;
                            st_next.tmo      = '0;
                            if (wr_byte_i != `ASAC_RST8) begin
                                cmd_wr_ev = 1'b1;
                                req_v     = 1'b1;
                                req_ch    = next_ch(wr_byte_i, `ASAC_LAST_CH);
                            end
                        end
                        `ASAC_PTR_SEQ:   st_next.seq = wr_byte_i;
                        `ASAC_PTR_VSTAT: st_next.vst = st_reg.vst & ~wr_byte_i;
                        `ASAC_PTR_ISTAT: st_next.ist = st_reg.ist & ~wr_byte_i;
                        `ASAC_PTR_TSTAT: st_next.tst = st_reg.tst & ~wr_byte_i;
                        default: ;
                    endcase
                    st_next.wph = asac_pkg::ASAC_W_PTR;
                end
            endcase
        end

        // Register reads, high byte first.
        if (rd_begin_i) begin
            st_next.rd_lo = 1'b0;
            st_next.tmo   = '0;
        end
        if (rd_byte_req_i) begin
            st_next.tmo = '0;
            if (st_reg.rd_lo) begin
                st_next.rd_byte = st_reg.rd_word[7:0];
                st_next.rd_lo   = 1'b0;
            end else begin
                case (st_reg.ptr)
                    `ASAC_PTR_RESULT: word = {st_reg.rhit | any_st, st_reg.res[14:0]};
                    `ASAC_PTR_CFG:    word = st_reg.cfg;
                    `ASAC_PTR_SEQ:    word = {`ASAC_RST8, st_reg.seq};
                    `ASAC_PTR_VSTAT:  word = {`ASAC_RST8, st_reg.vst};
                    `ASAC_PTR_ISTAT:  word = {`ASAC_RST8, st_reg.ist};
                    `ASAC_PTR_TSTAT:  word = {`ASAC_RST8, st_reg.tst};
                    default:          word = `ASAC_RST16;
                endcase
                wide            = st_reg.ptr == `ASAC_PTR_RESULT || st_reg.ptr == `ASAC_PTR_CFG;
                st_next.rd_word = word;
                st_next.rd_byte = wide ? word[15:8] : word[7:0];
                st_next.rd_lo   = wide;
                if (st_reg.ptr == `ASAC_PTR_RESULT && st_reg.cmd_on) begin
                    st_next.cmd_read = 1'b1;
                    if (st_reg.cmd_one) begin
                        st_next.cmd_on = 1'b0;
                    end else begin
                        req_v  = 1'b1;
                        req_ch = next_ch(st_reg.cmd_mask, st_reg.cur_ch);
                    end
                end
            end
        end
        if (rd_nack_i) begin
            st_next.cmd_on = 1'b0;
            st_next.rd_lo  = 1'b0;
        end
        if (bus_stop_i) begin
            st_next.wph = asac_pkg::ASAC_W_PTR;
            if (st_reg.cmd_on) begin
                if (st_reg.cmd_read) begin
                    st_next.cmd_on = 1'b0;
                end else begin
                    st_next.cmd_one = 1'b1;
                end
            end
        end

        // Results and sticky status; sets come after clears so an event is never lost.
        if (conv_done_i) begin
            st_next.conv_busy = 1'b0;
            st_next.res       = {1'b0, st_reg.cur_ch, conv_data_i};
            st_next.rhit      = conv_hi_i | conv_lo_i;
            unique case (st_reg.cur_ch[2:1])
                2'b00, 2'b01: begin
                    st_next.vst[pos]      = st_next.vst[pos] | conv_lo_i;
                    st_next.vst[pos + 3'h1] = st_next.vst[pos + 3'h1] | conv_hi_i;
                end
                2'b10: begin
                    st_next.ist[pos]      = st_next.ist[pos] | conv_lo_i;
                    st_next.ist[pos + 3'h1] = st_next.ist[pos + 3'h1] | conv_hi_i;
                end
                2'b11: begin
                    st_next.tst[pos]      = st_next.tst[pos] | conv_lo_i;
                    st_next.tst[pos + 3'h1] = st_next.tst[pos + 3'h1] | conv_hi_i;
                end
            endcase
        end
        st_next.ist[`ASAC_OVR_LSB +: 2] = st_next.ist[`ASAC_OVR_LSB +: 2] | pins_s[1:0];
        st_next.tst[`ASAC_OVERTEMP]     = st_next.tst[`ASAC_OVERTEMP] | pins_s[2];
        st_next.tst[`ASAC_DIODE_OPEN]   = st_next.tst[`ASAC_DIODE_OPEN] | (|pins_s[4:3]);
        st_next.tst[`ASAC_INT_LO]       = st_next.tst[`ASAC_INT_LO] | int_temp_lo_i;
        st_next.tst[`ASAC_INT_HI]       = st_next.tst[`ASAC_INT_HI] | int_temp_hi_i;

        // One converter: a request waits while a conversion is in flight.
        if (req_v) begin
            st_next.pend    = 1'b1;
            st_next.pend_ch = req_ch;
        end
        if (st_next.pend && !st_next.conv_busy) begin
            st_next.conv_start = 1'b1;
            st_next.conv_chan  = st_next.pend_ch;
            st_next.cur_ch     = st_next.pend_ch;
            st_next.conv_busy  = 1'b1;
            st_next.pend       = 1'b0;
        end
        st_next.alert = st_next.cfg[`ASAC_CFG_CLR_A] && st_next.cfg[`ASAC_CFG_CLR_B]
                      && (|{st_next.vst, st_next.ist, st_next.tst});
    end

    // ********************
    // State register
    // ********************
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg     <= '0;
            st_reg.wph <= asac_pkg::ASAC_W_PTR;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rd_byte_o    = st_reg.rd_byte;
    assign conv_start_o = st_reg.conv_start;
    assign conv_chan_o  = st_reg.conv_chan;
    assign cmd_mode_o   = st_reg.cmd_on;
    assign dac_hiz_o    = st_reg.tst[`ASAC_OVERTEMP];
    assign alert_pin_o  = st_reg.alert;

    // ********************
    // Checks
    // ********************
    logic rd_hi_res;
    assign rd_hi_res = rd_byte_req_i && !st_reg.rd_lo && st_reg.ptr == `ASAC_PTR_RESULT;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    chk_cmd_first: assert property (
        cmd_wr_ev && !st_reg.conv_busy && !st_reg.pend && !conv_done_i
        |=> conv_start_o && conv_chan_o == $past(req_ch) && cmd_mode_o)
        else $error("command write did not start first conversion");
    chk_read_next: assert property (
        rd_hi_res && st_reg.cmd_on && !st_reg.cmd_one && !st_reg.conv_busy && !st_reg.pend
        && !rd_nack_i && !bus_stop_i |=> conv_start_o)
        else $error("result read did not launch next conversion");
    chk_nack_exit: assert property (
        rd_nack_i |=> !cmd_mode_o)
        else $error("nack left on-demand mode active");
    chk_ptr_kept: assert property (
        cmd_wr_ev |=> st_reg.ptr == $past(st_reg.ptr))
        else $error("command write moved the pointer");
    chk_flag_any: assert property (
        rd_hi_res && any_st |=> rd_byte_o[7])
        else $error("result flag clear while status holds alerts");
    chk_hiz_set: assert property (
        $rose(pins_s[2]) |=> dac_hiz_o ##1 dac_hiz_o)
        else $error("overtemperature did not force high impedance");
    chk_sticky_bits: assert property (
        !(wr_valid_i && st_reg.wph != asac_pkg::ASAC_W_PTR) |=> ($past(st_reg.vst) & ~st_reg.vst) == '0)
        else $error("voltage status bit dropped without a write");
    chk_clear_ones: assert property (
        wr_valid_i && st_reg.wph == asac_pkg::ASAC_W_B8 && st_reg.wtgt == `ASAC_PTR_ISTAT
        && wr_byte_i == `ASAC_ALL_ONES && !conv_done_i && pins_s[1:0] == 2'h0
        |=> st_reg.ist == `ASAC_RST8)
        else $error("all-ones write left current status set");
    chk_stop_one: assert property (
        rd_hi_res && st_reg.cmd_on && st_reg.cmd_one |=> !cmd_mode_o)
        else $error("stop before read kept on-demand mode");

    cov_cmd_wrap: cover property (rd_hi_res && st_reg.cmd_on ##[1:1000] rd_hi_res && st_reg.cmd_on);
    cov_auto_conv: cover property (st_reg.cfg[`ASAC_CFG_AUTO] && conv_start_o);
    cov_tmo_exit: cover property (st_reg.cmd_on && st_reg.tmo == 20'(TMO_CYC - 1));
    cov_cfg_clear: cover property (any_st ##1 st_reg.vst == `ASAC_RST8 && st_reg.cfg[`ASAC_CFG_CLR_A]);
endmodule // asac_sequencer

// File: verilog/asac_defines.svh
// Purpose: Named offsets, field positions, reset values and times of the sequencer.
// Assumes: 100 MHz clock_i.
// Notes:   Definitions only.
`ifndef ASAC_DEFINES_SVH
`define ASAC_DEFINES_SVH
// ********************
// Register pointers
// ********************
`define ASAC_PTR_CMD     8'h00
`define ASAC_PTR_RESULT  8'h01
`define ASAC_PTR_VSTAT   8'h05
`define ASAC_PTR_ISTAT   8'h06
`define ASAC_PTR_TSTAT   8'h07
`define ASAC_PTR_SEQ     8'h08
`define ASAC_PTR_CFG     8'h09
// ********************
// Fields and resets
// ********************
`define ASAC_CFG_AUTO    12
`define ASAC_CFG_CLR_A   1
`define ASAC_CFG_CLR_B   2
`define ASAC_OVR_LSB     4
`define ASAC_OVERTEMP    6
`define ASAC_DIODE_OPEN  7
`define ASAC_INT_LO      4
`define ASAC_INT_HI      5
`define ASAC_FLAG_BIT    15
`define ASAC_LAST_CH     3'h7
`define ASAC_RST8        8'h00
`define ASAC_RST16       16'h0000
`define ASAC_ALL_ONES    8'hff
// ********************
// Times
// ********************
`define ASAC_CLK_NS      10
`define ASAC_TMO_MS      5
`define ASAC_AUTO_US     50
`define ASAC_TMO_CYC     ((`ASAC_TMO_MS * 1000000) / `ASAC_CLK_NS)
`define ASAC_AUTO_CYC    ((`ASAC_AUTO_US * 1000) / `ASAC_CLK_NS)
`endif

// File: verilog/asac_pkg.sv
// Purpose: Types shared by the sequencer files.
// Assumes: Counters fit in 20 bits.
// Notes:   Nothing here is imported.
package asac_pkg;
    typedef enum logic [3:0] {
        ASAC_W_PTR = 4'b0001,
        ASAC_W_B8  = 4'b0010,
        ASAC_W_HI  = 4'b0100,
        ASAC_W_LO  = 4'b1000
    } asac_wph_t;

    typedef struct packed {
        asac_wph_t   wph;
        logic [7:0]  ptr;
        logic [7:0]  wtgt;
        logic [7:0]  whi;
        logic [7:0]  cmd_mask;
        logic        cmd_on;
        logic        cmd_read;
        logic        cmd_one;
        logic [7:0]  seq;
        logic [15:0] cfg;
        logic [7:0]  vst;
        logic [7:0]  ist;
        logic [7:0]  tst;
        logic [15:0] res;
        logic        rhit;
        logic [2:0]  cur_ch;
        logic        conv_busy;
        logic        pend;
        logic [2:0]  pend_ch;
        logic        conv_start;
        logic [2:0]  conv_chan;
        logic [15:0] rd_word;
        logic        rd_lo;
        logic [7:0]  rd_byte;
        logic [19:0] tmo;
        logic [19:0] aut;
        logic        alert;
    } asac_state_t;
endpackage

// File: verilog/asac_pin_sync.sv
// Purpose: Three-stage synchroniser for asynchronous pins.
// Assumes: Pins are slow levels.
// Notes:   The output follows once stages two and three agree.
`timescale 1ns/1ps
module asac_pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clock_i,
    input  wire logic         rst_n_i,
    // Pins and result
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } asac_sync_t;

    asac_sync_t sync_reg;
    asac_sync_t sync_next;

    // The first stage feeds only the second, so metastability never reaches a gate.
    always_comb begin
        sync_next     = sync_reg;
        sync_next.s1  = pin_i;
        sync_next.s2  = sync_reg.s1;
        sync_next.s3  = sync_reg.s2;
        sync_next.lvl = (sync_reg.s2 & ~(sync_reg.s2 ^ sync_reg.s3))
                      | (sync_reg.lvl & (sync_reg.s2 ^ sync_reg.s3));
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign level_o = sync_reg.lvl;
endmodule // asac_pin_sync

// File: verification/asac_conv_model.sv
// Purpose: Converter and limit-compare model facing the sequencer.
// Assumes: One conversion in flight at a time.
// Notes:   Data inverts each cycle outside a done pulse so a capture one cycle late never matches.
`timescale 1ns/1ps
module asac_conv_model (
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    // Requests and limits
    input  wire logic       start_i,
    input  wire logic [2:0] chan_i,
    input  wire logic       slow_i,
    input  wire logic [7:0] hi_mask_i,
    input  wire logic [7:0] lo_mask_i,
    // Results
    output logic            done_o,
    output logic [11:0]     data_o,
    output logic            hi_o,
    output logic            lo_o
);
    logic [3:0] cnt_reg;
    logic [2:0] ch_reg;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= 4'h0;
            ch_reg  <= 3'h0;
            done_o  <= 1'b0;
            data_o  <= 12'h000;
            hi_o    <= 1'b0;
            lo_o    <= 1'b0;
        end else begin
            if (start_i) begin
                cnt_reg <= slow_i ? 4'h9 : 4'h2;
                ch_reg  <= chan_i;
            end else if (cnt_reg != 4'h0) begin
                cnt_reg <= cnt_reg - 4'h1;
            end
            done_o <= (cnt_reg == 4'h1);
            data_o <= (cnt_reg == 4'h1) ? {1'b0, ch_reg, 8'ha5} : ~data_o;
            hi_o   <= (cnt_reg == 4'h1) & hi_mask_i[ch_reg];
            lo_o   <= (cnt_reg == 4'h1) & lo_mask_i[ch_reg];
        end
    end
endmodule // asac_conv_model

// File: verification/adc_sequencer_alert_control_test.sv
// Purpose: Self-checking bench of the sequencer against a bench status model.
// Assumes: Short timeout and pacing parameters.
// Notes:   The bench plays the bus engine; the model plays the converter.
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin num_errors++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (a), (e)); end end
module adc_sequencer_alert_control_test;
    logic        clock_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [5:0]  ev = 6'h00;
    logic [7:0]  wr_byte = 8'h00, hm = 8'h00, lm = 8'h00, h, l, seq;
    logic [1:0]  ovr = 2'b00, dio = 2'b00;
    logic        ot = 1'b0, t_hi = 1'b0, t_lo = 1'b0, slow = 1'b1;
    logic        c_start, c_done, c_hi, c_lo;
    logic [2:0]  c_chan, ch;
    logic [11:0] c_data;
    logic [7:0]  rd_byte_o;
    logic        cmd_mode_o, dac_hiz_o, alert_pin_o;
    logic [15:0] v;
    int          num_errors = 0, samples_checked = 0, vs = 0, is_ = 0, n, seed = 8732;
    asac_sequencer #(.TMO_CYC(40), .AUTO_CYC(20)) uut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .bus_start_i(ev[0]), .bus_stop_i(ev[1]),
        .wr_valid_i(ev[5]), .wr_byte_i(wr_byte), .rd_begin_i(ev[2]), .rd_byte_req_i(ev[3]),
        .rd_nack_i(ev[4]), .rd_byte_o(rd_byte_o), .conv_start_o(c_start),
        .conv_chan_o(c_chan), .conv_done_i(c_done), .conv_data_i(c_data), .conv_hi_i(c_hi),
        .conv_lo_i(c_lo), .int_temp_hi_i(t_hi), .int_temp_lo_i(t_lo), .ovr_pin_i(ovr),
        .overtemp_pin_i(ot), .diode_open_pin_i(dio), .cmd_mode_o(cmd_mode_o),
        .dac_hiz_o(dac_hiz_o), .alert_pin_o(alert_pin_o));
    asac_conv_model conv (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .start_i(c_start), .chan_i(c_chan),
        .slow_i(slow), .hi_mask_i(hm), .lo_mask_i(lm), .done_o(c_done), .data_o(c_data),
        .hi_o(c_hi), .lo_o(c_lo));
    // ********************
    // Bus engine tasks
    // ********************
    task ev1(input int i);
        @(posedge clock_i);
        ev[i] <= 1'b1;
        @(posedge clock_i);
        ev <= 6'h00;
    endtask
    task wr(input logic [7:0] b);
        wr_byte <= b;
        ev1(5);
    endtask
    task rd(output logic [7:0] b);
        ev1(3);
        @(negedge clock_i);
        b = rd_byte_o;
    endtask
    task wr8(input logic [7:0] p, input logic [7:0] d);
        ev1(0); wr(p); wr(d); ev1(1);
    endtask
    task wr16(input logic [7:0] p, input logic [15:0] d);
        ev1(0); wr(p); wr(d[15:8]); wr(d[7:0]); ev1(1);
    endtask
    task rdreg(input logic [7:0] p, output logic [15:0] r);
        ev1(0); wr(p); ev1(0); ev1(2); rd(r[15:8]); rd(r[7:0]); ev1(4); ev1(1);
    endtask
    // Bench copy of the sticky limit bits, lower limit at 2k and upper at 2k+1.
    task st(input logic [2:0] c);
        if (c < 3'h4) vs |= (int'(hm[c]) << (2 * c + 1)) | (int'(lm[c]) << (2 * c));
        else is_ |= (int'(hm[c]) << (2 * c - 7)) | (int'(lm[c]) << (2 * c - 8));
    endtask
    task close_out;
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        forever #5 clock_i = ~clock_i;
    end
    initial begin
        #100000;
        num_errors++;
        close_out;
    end
    // ********************
    // Scenarios
    // ********************
    initial begin
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        rdreg(8'h09, v);
        `CHK({v, cmd_mode_o}, 17'h00000)
        wr8(8'h06, 8'h30);
        hm <= 8'h02;
        lm <= 8'h10;
        ev1(0); wr(8'h00); wr(8'h13); wr(8'h01);
        `CHK(cmd_mode_o, 1'b1)
        ev1(0); ev1(2);
        for (int i = 0; i < 5; i++) begin
            ch = (i % 3 == 2) ? 3'h4 : 3'(i % 3);
            st(ch);
            repeat (12) @(posedge clock_i);
            rd(h); rd(l);
            `CHK({h, l}, {((vs | is_) != 0), ch, 1'b0, ch, 8'ha5})
        end
        ev1(4);
        @(negedge clock_i);
        `CHK(cmd_mode_o, 1'b0)
        ev1(1);
        hm <= 8'h00;
        lm <= 8'h00;
        rdreg(8'h05, v);
        `CHK(v[7:0], vs[7:0])
        wr8(8'h05, 8'h08); rdreg(8'h05, v);
        `CHK(v[7:0], 8'h00)
        ovr <= 2'b10; ot <= 1'b1; dio <= 2'b01; t_hi <= 1'b1;
        @(posedge clock_i) t_hi <= 1'b0;
        repeat (8) @(posedge clock_i);
        ovr <= 2'b00; ot <= 1'b0; dio <= 2'b00;
        repeat (6) @(posedge clock_i);
        `CHK(dac_hiz_o, 1'b1)
        rdreg(8'h06, v);
        `CHK(v[7:0], 8'(is_) | 8'h20)
        rdreg(8'h07, v);
        `CHK(v[7:0], 8'he0)
        wr8(8'h06, 8'hff); rdreg(8'h06, v);
        `CHK(v[7:0], 8'h00)
        wr16(8'h09, 16'h0006); rdreg(8'h07, v);
        `CHK({v[7:0], dac_hiz_o}, 9'h000)
        @(posedge clock_i) t_lo <= 1'b1;
        @(posedge clock_i) t_lo <= 1'b0;
        repeat (3) @(posedge clock_i);
        `CHK(alert_pin_o, 1'b1)
        rdreg(8'h07, v);
        `CHK(v[7:0], 8'h10)
        wr8(8'h07, 8'hff); repeat (2) @(posedge clock_i);
        `CHK(alert_pin_o, 1'b0)
        ev1(0); wr(8'h00); wr(8'h01); ev1(1); repeat (12) @(posedge clock_i);
        ev1(0); wr(8'h01); ev1(0); ev1(2); rd(h); rd(l); ev1(4); ev1(1);
        `CHK({h, l, cmd_mode_o}, 17'h0014a)
        ev1(0); wr(8'h00); wr(8'h01); ev1(1);
        `CHK(cmd_mode_o, 1'b1)
        repeat (60) @(posedge clock_i);
        `CHK(cmd_mode_o, 1'b0)
        seq = (8'($random(seed)) & 8'h0f) | 8'h01;
        slow <= 1'b0;
        wr8(8'h08, seq); wr16(8'h09, 16'h1000);
        n = 0;
        repeat (205) begin
            @(negedge clock_i);
            if (c_start === 1'b1) begin
                n++;
                `CHK(seq[c_chan], 1'b1)
            end
        end
        `CHK(n >= 9 && n <= 12, 1'b1)
        rdreg(8'h01, v);
        `CHK({seq[v[14:12]], v[7:0]}, 9'h1a5)
        wr16(8'h09, 16'h0000); repeat (5) @(posedge clock_i);
        n = 0;
        repeat (60) @(negedge clock_i) if (c_start === 1'b1) n++;
        `CHK(n, 0)
        ev1(0); wr(8'h00); wr(8'h02); wr(8'h01); ev1(0); ev1(2);
        repeat (4) @(posedge clock_i);
        rd(h); rd(l); ev1(4); ev1(1); wr8(8'h07, 8'hff);
        `CHK({h, l, cmd_mode_o}, 17'h0234a)
        close_out;
    end
endmodule // adc_sequencer_alert_control_test
